// >>> common/msd_pkg.sv
package msd_pkg;
   // ------------------------------------------------------------------
   // Program space layout.
   // ------------------------------------------------------------------
   localparam int          PROG_AW          = 24;
   localparam int          PC_W             = 23;
   localparam logic [23:0] PROG_USER_LAST   = 24'h7FFFFF;
   localparam logic [23:0] RESET_JUMP_ADDR  = 24'h000000;
   localparam logic [23:0] RESET_TGT_ADDR   = 24'h000002;
   localparam logic [23:0] PRI_IVT_FIRST    = 24'h000004;
   localparam logic [23:0] PRI_IVT_LAST     = 24'h0000FF;
   localparam logic [23:0] ALT_IVT_FIRST    = 24'h000100;
   localparam logic [23:0] VECTOR_END       = 24'h000200;
   localparam logic [22:0] PC_STEP          = 23'h000002;
   localparam logic [22:0] PC_RESET         = 23'h000000;
   localparam int          TBLPG_CFG_BIT    = 7;
   localparam int          PROG_WORD_W      = 24;
   localparam logic [7:0]  UPPER_PAD        = 8'h00;

   // ------------------------------------------------------------------
   // Data space layout.
   // ------------------------------------------------------------------
   localparam int          DATA_AW          = 16;
   localparam int          DATA_W           = 16;
   localparam int          PSV_BIT          = 15;
   localparam logic [15:0] SFR_LAST         = 16'h07FF;
   localparam logic [15:0] RAM_LAST         = 16'h7FFF;
   localparam logic [15:0] RAM_LIMIT        = 16'h77FF;
   localparam int          RAM_WORDS        = 15360;
   localparam int          RAM_IDX_W        = 14;
   localparam logic [15:0] ZERO_WORD        = 16'h0000;

   // ------------------------------------------------------------------
   // Program region classes.
   // ------------------------------------------------------------------
   localparam logic [2:0]  RGN_RESET        = 3'h0;
   localparam logic [2:0]  RGN_PRI_IVT      = 3'h1;
   localparam logic [2:0]  RGN_ALT_IVT      = 3'h2;
   localparam logic [2:0]  RGN_USER         = 3'h3;
   localparam logic [2:0]  RGN_CONFIG       = 3'h4;
   localparam logic [2:0]  RGN_DENIED       = 3'h5;

   // Data region classes.
   localparam logic [1:0]  DRG_SFR          = 2'h0;
   localparam logic [1:0]  DRG_RAM          = 2'h1;
   localparam logic [1:0]  DRG_UNIMPL       = 2'h2;
   localparam logic [1:0]  DRG_PSV          = 2'h3;

   // Program counter sequencing states.
   typedef enum logic [2:0] {
      MSD_PC_RESET = 3'b001,
      MSD_PC_RUN   = 3'b010,
      MSD_PC_HOLD  = 3'b100
   } msd_pc_state_t;
endpackage

// >>> verilog/msd_prog_decode.sv
`timescale 1ns/1ps
// Classifies a 24-bit program address into its region and access grant.
module msd_prog_decode (
   input  wire logic [23:0] i_addr,
   input  wire logic        i_table_op,
   input  wire logic        i_cfg_page,
   output logic      [2:0]  o_region,
   output logic             o_allow
);
   // ------------------------------------------------------------------
   // Region decode.
   // ------------------------------------------------------------------
   // Ordinary access stops at the top of the user half; table ops may go
   // above it only when the configuration page bit is set.
   always_comb begin
      o_allow = 1'b1;
      if (i_addr < msd_pkg::PRI_IVT_FIRST) begin
         o_region = msd_pkg::RGN_RESET;
      end else if (i_addr <= msd_pkg::PRI_IVT_LAST) begin
         o_region = msd_pkg::RGN_PRI_IVT;
      end else if (i_addr < msd_pkg::VECTOR_END) begin
         o_region = msd_pkg::RGN_ALT_IVT;
      end else if (i_addr <= msd_pkg::PROG_USER_LAST) begin
         o_region = msd_pkg::RGN_USER;
      end else if (i_table_op && i_cfg_page) begin
         o_region = msd_pkg::RGN_CONFIG;
      end else begin
         o_region = msd_pkg::RGN_DENIED;
         o_allow  = 1'b0;
      end
   end
endmodule

// >>> verilog/msd_data_decode.sv
`timescale 1ns/1ps
// Classifies a 16-bit data effective address.
module msd_data_decode (
   input  wire logic [15:0] i_addr,
   output logic      [1:0]  o_region
);
   // ------------------------------------------------------------------
   // Region decode.
   // ------------------------------------------------------------------
   // The top bit alone steers to the visibility window.
   always_comb begin
      if (i_addr[msd_pkg::PSV_BIT]) begin
         o_region = msd_pkg::DRG_PSV;
      end else if (i_addr <= msd_pkg::SFR_LAST) begin
         o_region = msd_pkg::DRG_SFR;
      end else if (i_addr <= msd_pkg::RAM_LIMIT) begin
         o_region = msd_pkg::DRG_RAM;
      end else begin
         o_region = msd_pkg::DRG_UNIMPL;
      end
   end
endmodule

// >>> verilog/msd_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Program address is 24 bits from PC or table
// - User program access limited to lower half
// - Table ops reach config only with page bit 7
// - Location is lower and upper word, top byte empty
// - Lower word even, upper word odd address
// - Program counter steps by two per location
// - First 0x200 addresses reserved for vectors
// - Reset starts at zero, jump target at two
// - Primary and alternate vector tables
// - Separate read and write data address units
// - Data address is 16-bit byte address
// - Address bit 15 selects visibility window
// - Reads outside implemented memory return zero
// - Low byte even address, high byte odd
// - Odd word access traps; faulting write suppressed
// - Byte read selects lane; byte write one lane
// - Low 2 KB is register space, unused reads zero
module msd_top (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   // Program fetch side.
   input  wire logic        i_pc_load,
   input  wire logic [22:0] i_pc_load_value,
   input  wire logic        i_pc_step,
   input  wire logic        i_pc_down,
   input  wire logic        i_vector_sel,
   input  wire logic        i_vector_alt,
   input  wire logic [6:0]  i_vector_num,
   input  wire logic        i_table_req,
   input  wire logic        i_table_wr,
   input  wire logic [7:0]  i_table_page_register,
   input  wire logic [15:0] i_table_offset,
   input  wire logic        i_table_upper,
   output logic      [23:0] o_prog_addr,
   output logic             o_prog_upper,
   output logic      [2:0]  o_prog_region,
   output logic             o_prog_allow,
   output logic      [22:0] o_program_counter,
   // Program word lanes returned by the memory.
   input  wire logic [23:0] i_prog_rdata,
   output logic      [15:0] o_prog_word,
   // Data read unit.
   input  wire logic        i_rd_req,
   input  wire logic        i_rd_byte,
   input  wire logic [15:0] i_rd_ea,
   input  wire logic [15:0] i_sfr_rdata,
   input  wire logic        i_sfr_hit,
   output logic             o_rd_valid,
   output logic      [15:0] o_rd_data,
   output logic             o_rd_psv,
   output logic      [15:0] o_psv_addr,
   // Data write unit.
   input  wire logic        i_wr_req,
   input  wire logic        i_wr_byte,
   input  wire logic [15:0] i_wr_ea,
   input  wire logic [15:0] i_wr_data,
   output logic             o_sfr_we,
   output logic      [1:0]  o_sfr_lane,
   output logic      [15:0] o_sfr_addr,
   output logic      [15:0] o_sfr_wdata,
   output logic             o_addr_trap
);
   // ------------------------------------------------------------------
   // Program counter state.
   // ------------------------------------------------------------------
   msd_pkg::msd_pc_state_t pc_state_q, pc_state_d;
   logic [22:0] pc_q, pc_d;

   // The counter restarts at the reset jump and walks by two so that it
   // always lands on the even lower word of a location.
   always_comb begin
      pc_state_d = pc_state_q;
      pc_d       = pc_q;
      case (pc_state_q)
         msd_pkg::MSD_PC_RESET: begin
            pc_d       = msd_pkg::PC_RESET;
            pc_state_d = msd_pkg::MSD_PC_RUN;
         end
         msd_pkg::MSD_PC_RUN: begin
            if (i_vector_sel) begin
               pc_d = i_vector_alt ?
                  23'(msd_pkg::ALT_IVT_FIRST + {15'h0000, i_vector_num, 1'b0})
                : 23'(msd_pkg::PRI_IVT_FIRST + {15'h0000, i_vector_num, 1'b0});
            end else if (i_pc_load) begin
               pc_d = {i_pc_load_value[22:1], 1'b0};
            end else if (i_pc_step) begin
               pc_d = i_pc_down ? pc_q - msd_pkg::PC_STEP
                                : pc_q + msd_pkg::PC_STEP;
            end
            if (i_table_req) begin
               pc_state_d = msd_pkg::MSD_PC_HOLD;
            end
         end
         msd_pkg::MSD_PC_HOLD: begin
            // The counter holds for one cycle after a table op, then returns to run.
            pc_state_d = msd_pkg::MSD_PC_RUN;
         end
         default: begin
            pc_state_d = msd_pkg::MSD_PC_RESET;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pc_state_q <= msd_pkg::MSD_PC_RESET;
         pc_q       <= msd_pkg::PC_RESET;
      end else if (i_ce) begin
         pc_state_q <= pc_state_d;
         pc_q       <= pc_d;
      end
   end

   // ------------------------------------------------------------------
   // Program address formation.
   // ------------------------------------------------------------------
   logic [23:0] paddr_c;
   logic        pupper_c;
   logic        table_c;
   logic [2:0]  pregion_c;
   logic        pallow_c;

   // A table op borrows the page register for the top byte; otherwise
   // the counter is zero-extended to the full 24 bits.
   always_comb begin
      table_c = i_table_req;
      if (table_c) begin
         paddr_c  = {i_table_page_register, i_table_offset[15:1], 1'b0};
         pupper_c = i_table_upper;
      end else begin
         paddr_c  = {1'b0, pc_q};
         pupper_c = 1'b0;
      end
   end

   msd_prog_decode u_prog_decode (
      .i_addr     (paddr_c),
      .i_table_op (table_c),
      .i_cfg_page (i_table_page_register[msd_pkg::TBLPG_CFG_BIT]),
      .o_region   (pregion_c),
      .o_allow    (pallow_c)
   );

   // ------------------------------------------------------------------
   // Program output registers.
   // ------------------------------------------------------------------
   logic [23:0] prog_addr_q, prog_addr_d;
   logic        prog_upper_q, prog_upper_d;
   logic [2:0]  prog_region_q, prog_region_d;
   logic        prog_allow_q, prog_allow_d;
   logic [15:0] prog_word_q, prog_word_d;

   // The odd word carries only the upper byte; its top byte is empty.
   always_comb begin
      prog_addr_d   = paddr_c;
      prog_upper_d  = pupper_c;
      prog_region_d = pregion_c;
      prog_allow_d  = pallow_c;
      if (!prog_allow_q) begin
         prog_word_d = msd_pkg::ZERO_WORD;
      end else if (prog_upper_q) begin
         prog_word_d = {msd_pkg::UPPER_PAD, i_prog_rdata[23:16]};
      end else begin
         prog_word_d = i_prog_rdata[15:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prog_addr_q   <= msd_pkg::RESET_JUMP_ADDR;
         prog_upper_q  <= 1'b0;
         prog_region_q <= msd_pkg::RGN_RESET;
         prog_allow_q  <= 1'b1;
         prog_word_q   <= msd_pkg::ZERO_WORD;
      end else if (i_ce) begin
         prog_addr_q   <= prog_addr_d;
         prog_upper_q  <= prog_upper_d;
         prog_region_q <= prog_region_d;
         prog_allow_q  <= prog_allow_d;
         prog_word_q   <= prog_word_d;
      end
   end

   // ------------------------------------------------------------------
   // Data memory array.
   // ------------------------------------------------------------------
   // Two byte lanes share one word index but have their own write lines.
   logic [7:0] ram_lo [0:msd_pkg::RAM_WORDS-1];
   logic [7:0] ram_hi [0:msd_pkg::RAM_WORDS-1];

   logic [1:0] rd_region_c;
   logic [1:0] wr_region_c;

   msd_data_decode u_rd_decode (
      .i_addr   (i_rd_ea),
      .o_region (rd_region_c)
   );

   msd_data_decode u_wr_decode (
      .i_addr   (i_wr_ea),
      .o_region (wr_region_c)
   );

   logic [13:0] rd_idx_c;
   logic [13:0] wr_idx_c;
   assign rd_idx_c = 14'(i_rd_ea[14:1] - msd_pkg::SFR_LAST[14:1] - 14'h0001);
   assign wr_idx_c = 14'(i_wr_ea[14:1] - msd_pkg::SFR_LAST[14:1] - 14'h0001);

   // ------------------------------------------------------------------
   // Read and write address units.
   // ------------------------------------------------------------------
   logic        rd_trap_c, wr_trap_c;
   logic        wr_go_c;
   logic [1:0]  lane_c;
   logic [15:0] word_c;

   // Word accesses must be even; a faulting write is dropped but the trap
   // still fires so the core can finish the instruction.
   always_comb begin
      rd_trap_c = i_rd_req && !i_rd_byte && i_rd_ea[0];
      wr_trap_c = i_wr_req && !i_wr_byte && i_wr_ea[0];
      wr_go_c   = i_wr_req && !wr_trap_c;
      if (i_wr_byte) begin
         lane_c = i_wr_ea[0] ? 2'b10 : 2'b01;
         word_c = {i_wr_data[7:0], i_wr_data[7:0]};
      end else begin
         lane_c = 2'b11;
         word_c = i_wr_data;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_ce && wr_go_c && wr_region_c == msd_pkg::DRG_RAM) begin
         if (lane_c[0]) begin
            ram_lo[wr_idx_c] <= word_c[7:0];
         end
         if (lane_c[1]) begin
            ram_hi[wr_idx_c] <= word_c[15:8];
         end
      end
   end

   logic [15:0] ram_word_c;
   logic [15:0] rd_word_c;
   logic [15:0] rd_data_d, rd_data_q;
   logic        rd_valid_d, rd_valid_q;
   logic        rd_psv_d, rd_psv_q;
   logic [15:0] psv_addr_d, psv_addr_q;
   logic        trap_d, trap_q;
   logic        sfr_we_d, sfr_we_q;
   logic [1:0]  sfr_lane_d, sfr_lane_q;
   logic [15:0] sfr_addr_d, sfr_addr_q;
   logic [15:0] sfr_wdata_d, sfr_wdata_q;

   assign ram_word_c = {ram_hi[rd_idx_c], ram_lo[rd_idx_c]};

   // Holes read zero; a byte read lands on the low byte of the answer.
   always_comb begin
      case (rd_region_c)
         msd_pkg::DRG_RAM:    rd_word_c = ram_word_c;
         msd_pkg::DRG_SFR:    rd_word_c = i_sfr_hit ? i_sfr_rdata
                                                    : msd_pkg::ZERO_WORD;
         default:             rd_word_c = msd_pkg::ZERO_WORD;
      endcase
      rd_valid_d  = i_rd_req;
      rd_psv_d    = i_rd_req && rd_region_c == msd_pkg::DRG_PSV;
      psv_addr_d  = i_rd_ea;
      if (i_rd_byte) begin
         rd_data_d = {8'h00, i_rd_ea[0] ? rd_word_c[15:8] : rd_word_c[7:0]};
      end else begin
         rd_data_d = rd_word_c;
      end
      if (!i_rd_req) begin
         rd_data_d = msd_pkg::ZERO_WORD;
      end
      trap_d      = rd_trap_c || wr_trap_c;
      sfr_we_d    = wr_go_c && wr_region_c == msd_pkg::DRG_SFR;
      sfr_lane_d  = lane_c;
      sfr_addr_d  = {i_wr_ea[15:1], 1'b0};
      sfr_wdata_d = word_c;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_data_q   <= msd_pkg::ZERO_WORD;
         rd_valid_q  <= 1'b0;
         rd_psv_q    <= 1'b0;
         psv_addr_q  <= msd_pkg::ZERO_WORD;
         trap_q      <= 1'b0;
         sfr_we_q    <= 1'b0;
         sfr_lane_q  <= 2'b00;
         sfr_addr_q  <= msd_pkg::ZERO_WORD;
         sfr_wdata_q <= msd_pkg::ZERO_WORD;
      end else if (i_ce) begin
         rd_data_q   <= rd_data_d;
         rd_valid_q  <= rd_valid_d;
         rd_psv_q    <= rd_psv_d;
         psv_addr_q  <= psv_addr_d;
         trap_q      <= trap_d;
         sfr_we_q    <= sfr_we_d;
         sfr_lane_q  <= sfr_lane_d;
         sfr_addr_q  <= sfr_addr_d;
         sfr_wdata_q <= sfr_wdata_d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs.
   // ------------------------------------------------------------------
   assign o_program_counter = pc_q;
   assign o_prog_addr       = prog_addr_q;
   assign o_prog_upper      = prog_upper_q;
   assign o_prog_region     = prog_region_q;
   assign o_prog_allow      = prog_allow_q;
   assign o_prog_word       = prog_word_q;
   assign o_rd_valid        = rd_valid_q;
   assign o_rd_data         = rd_data_q;
   assign o_rd_psv          = rd_psv_q;
   assign o_psv_addr        = psv_addr_q;
   assign o_addr_trap       = trap_q;
   assign o_sfr_we          = sfr_we_q;
   assign o_sfr_lane        = sfr_lane_q;
   assign o_sfr_addr        = sfr_addr_q;
   assign o_sfr_wdata       = sfr_wdata_q;
endmodule

// >>> test/msd_far_model.sv
`timescale 1ns/1ps
// --------------------
// Far side: program store and register space.
// --------------------
module msd_far_model (
   input  wire logic [23:0] i_prog_addr,
   input  wire logic [15:0] i_rd_ea,
   output logic      [23:0] o_prog_rdata,
   output logic      [15:0] o_sfr_rdata,
   output logic             o_sfr_hit
);
   // An address-tied pattern makes a wrong fetch or lane show up.
   assign o_prog_rdata = {i_prog_addr[7:0] ^ 8'h5A, i_prog_addr[15:0] ^ 16'h3C00};

   // Registers fill the first 256 bytes; elsewhere junk, not zero.
   always_comb begin
      o_sfr_hit   = (i_rd_ea[15:8] == 8'h00);
      o_sfr_rdata = o_sfr_hit ? (16'hC000 | i_rd_ea) : ~i_rd_ea;
   end
endmodule

// >>> test/msd_top_assertions.sv
`timescale 1ns/1ps
// --------------------
// Port checker for the address decoder.
// --------------------
module msd_top_chk (
   input wire logic        i_sys_clk,
   input wire logic        i_rst_n,
   input wire logic        i_ce,
   input wire logic        i_pc_step,
   input wire logic        i_pc_down,
   input wire logic        i_pc_load,
   input wire logic        i_vector_sel,
   input wire logic        i_vector_alt,
   input wire logic [6:0]  i_vector_num,
   input wire logic        i_table_req,
   input wire logic [7:0]  i_table_page_register,
   input wire logic        i_rd_req,
   input wire logic        i_rd_byte,
   input wire logic [15:0] i_rd_ea,
   input wire logic        i_wr_req,
   input wire logic        i_wr_byte,
   input wire logic [15:0] i_wr_ea,
   input wire logic [22:0] o_program_counter,
   input wire logic [2:0]  o_prog_region,
   input wire logic        o_prog_allow,
   input wire logic        o_rd_valid,
   input wire logic [15:0] o_rd_data,
   input wire logic        o_rd_psv,
   input wire logic        o_sfr_we,
   input wire logic [1:0]  o_sfr_lane,
   input wire logic        o_addr_trap
);
   logic rd_go, wr_go;

   // A request counts only while the enable lets state move.
   assign rd_go = i_rd_req & i_ce;
   assign wr_go = i_wr_req & i_ce;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_rd_answer_next: assert property (rd_go |=> o_rd_valid)
      else $error("read answer missing");
   a_pc_step_two: assert property (
      i_ce && i_pc_step && !i_pc_load && !i_vector_sel |=> o_program_counter ==
      ($past(i_pc_down) ? $past(o_program_counter) - 23'h2
                        : $past(o_program_counter) + 23'h2))
      else $error("counter step not two");
   a_vector_entry: assert property (
      i_ce && i_vector_sel |=> o_program_counter ==
      (($past(i_vector_alt) ? 23'h100 : 23'h4) + {15'h0, $past(i_vector_num), 1'b0}))
      else $error("vector entry wrong");
   a_odd_read_trap: assert property (rd_go && !i_rd_byte && i_rd_ea[0] |=> o_addr_trap)
      else $error("odd read no trap");
   a_odd_write_drop: assert property (
      wr_go && !i_wr_byte && i_wr_ea[0] |=> o_addr_trap && !o_sfr_we)
      else $error("odd write not refused");
   a_window_zero: assert property (
      rd_go && i_rd_ea[15] |=> o_rd_psv && o_rd_data == 16'h0000)
      else $error("window read not routed");
   a_unimpl_zero: assert property (rd_go && i_rd_ea[15:11] == 5'h0F |=> o_rd_data == 16'h0000)
      else $error("hole read not zero");
   a_byte_read_lane: assert property (rd_go && i_rd_byte |=> o_rd_data[15:8] == 8'h00)
      else $error("byte read high not zero");
   a_odd_byte_lane: assert property (
      wr_go && i_wr_byte && i_wr_ea[0] && i_wr_ea[15:11] == 5'h00 |=> o_sfr_we && o_sfr_lane == 2'b10)
      else $error("odd byte lane wrong");
   a_word_both_lanes: assert property (
      wr_go && !i_wr_byte && !i_wr_ea[0] && i_wr_ea[15:11] == 5'h00 |=> o_sfr_we && o_sfr_lane == 2'b11)
      else $error("word write lanes wrong");
   a_cfg_table_page: assert property (
      i_ce && i_table_req && i_table_page_register[7] |=>
      o_prog_region == msd_pkg::RGN_CONFIG && o_prog_allow)
      else $error("config table access wrong");

   c_byte_read: cover property (rd_go && i_rd_byte);
   c_alt_vector: cover property (i_ce && i_vector_sel && i_vector_alt);
   c_trap_seen: cover property (o_addr_trap);
endmodule

bind msd_top msd_top_chk u_chk (
   .i_sys_clk, .i_rst_n, .i_ce, .i_pc_step, .i_pc_down, .i_pc_load, .i_vector_sel,
   .i_vector_alt, .i_vector_num, .i_table_req, .i_table_page_register, .i_rd_req, .i_rd_byte,
   .i_rd_ea, .i_wr_req, .i_wr_byte, .i_wr_ea, .o_program_counter, .o_prog_region,
   .o_prog_allow, .o_rd_valid, .o_rd_data, .o_rd_psv, .o_sfr_we, .o_sfr_lane, .o_addr_trap
);

// >>> test/tb_top.sv
`timescale 1ns/1ps
// --------------------
// Self-checking bench for the address decoder.
// --------------------
module tb_top;
   logic        i_sys_clk, i_rst_n, i_ce, i_pc_load, i_pc_step, i_pc_down, i_vector_sel;
   logic        i_vector_alt, i_table_req, i_table_wr, i_table_upper, i_sfr_hit;
   logic        i_rd_req, i_rd_byte, i_wr_req, i_wr_byte;
   logic [6:0]  i_vector_num;
   logic [7:0]  i_table_page_register;
   logic [15:0] i_table_offset, i_rd_ea, i_sfr_rdata, i_wr_ea, i_wr_data;
   logic [22:0] i_pc_load_value, o_program_counter;
   logic [23:0] i_prog_rdata, o_prog_addr;
   logic        o_prog_upper, o_prog_allow, o_rd_valid, o_rd_psv, o_sfr_we, o_addr_trap;
   logic [1:0]  o_sfr_lane;
   logic [2:0]  o_prog_region;
   logic [15:0] o_prog_word, o_rd_data, o_psv_addr, o_sfr_addr, o_sfr_wdata;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          cyc_count = 0;

   msd_top dut (
      .i_sys_clk, .i_rst_n, .i_ce, .i_pc_load, .i_pc_load_value, .i_pc_step, .i_pc_down,
      .i_vector_sel, .i_vector_alt, .i_vector_num, .i_table_req, .i_table_wr,
      .i_table_page_register, .i_table_offset, .i_table_upper, .o_prog_addr, .o_prog_upper,
      .o_prog_region, .o_prog_allow, .o_program_counter, .i_prog_rdata, .o_prog_word,
      .i_rd_req, .i_rd_byte, .i_rd_ea, .i_sfr_rdata, .i_sfr_hit, .o_rd_valid, .o_rd_data,
      .o_rd_psv, .o_psv_addr, .i_wr_req, .i_wr_byte, .i_wr_ea, .i_wr_data, .o_sfr_we,
      .o_sfr_lane, .o_sfr_addr, .o_sfr_wdata, .o_addr_trap
   );
   msd_far_model u_far (
      .i_prog_addr(o_prog_addr), .i_rd_ea, .o_prog_rdata(i_prog_rdata),
      .o_sfr_rdata(i_sfr_rdata), .o_sfr_hit(i_sfr_hit)
   );

   // Free-running 250 MHz clock.
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   // A hang is cut off far past what the tests need.
   always @(posedge i_sys_clk) begin
      cyc_count++;
      if (cyc_count == 2000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   function automatic logic [23:0] pat(input logic [23:0] a);
      return {a[7:0] ^ 8'h5A, a[15:0] ^ 16'h3C00};
   endfunction

   // One counter operation, judged after the edge that takes it.
   task automatic pc_op(input logic [4:0] ctl, input logic [6:0] vn, input logic [22:0] lv,
                        input logic [22:0] exp);
      @(negedge i_sys_clk);
      {i_pc_load, i_pc_step, i_pc_down, i_vector_sel, i_vector_alt} = ctl;
      i_vector_num = vn;
      i_pc_load_value = lv;
      @(negedge i_sys_clk);
      {i_pc_load, i_pc_step, i_vector_sel} = 3'b000;
      check(o_program_counter, exp);
   endtask

   // Table fetch over two cycles: address, then returned word.
   task automatic tbl(input logic [7:0] pg, input logic [15:0] off, input logic up,
                      input logic [2:0] rgn);
      logic [23:0] a;
      logic [23:0] d;
      a = {pg, off[15:1], 1'b0};
      d = pat(a);
      @(negedge i_sys_clk);
      i_table_req = 1'b1;
      i_table_page_register = pg;
      i_table_offset = off;
      i_table_upper = up;
      @(negedge i_sys_clk);
      check(o_prog_addr, a);
      check(o_prog_upper, up);
      check(o_prog_region, rgn);
      check(o_prog_allow, 1'b1);
      @(negedge i_sys_clk);
      i_table_req = 1'b0;
      check(o_prog_word, up ? {16'h0, d[23:16]} : {8'h0, d[15:0]});
   endtask

   task automatic rd(input logic [15:0] ea, input logic byt, input logic [15:0] exp);
      @(negedge i_sys_clk);
      i_rd_req = 1'b1;
      i_rd_byte = byt;
      i_rd_ea = ea;
      @(negedge i_sys_clk);
      i_rd_req = 1'b0;
      check(o_rd_valid, 1'b1);
      check(o_rd_psv, ea[15]);
      check(o_addr_trap, ea[0] & ~byt);
      check(o_psv_addr, ea);
      check(o_rd_data, exp);
   endtask

   task automatic wr(input logic [15:0] ea, input logic byt, input logic [15:0] d);
      @(negedge i_sys_clk);
      i_wr_req = 1'b1;
      i_wr_byte = byt;
      i_wr_ea = ea;
      i_wr_data = d;
      @(negedge i_sys_clk);
      i_wr_req = 1'b0;
   endtask

   task automatic t_reset();
      check(o_program_counter, 23'h000000);
      check(o_prog_region, msd_pkg::RGN_RESET);
      check(o_prog_allow, 1'b1);
      check({o_rd_valid, o_sfr_we, o_addr_trap}, 3'b000);
      $display("reset test done");
   endtask

   task automatic t_pc();
      pc_op(5'b01000, 7'h0, 23'h0, 23'h2);
      pc_op(5'b01000, 7'h0, 23'h0, 23'h4);
      pc_op(5'b01100, 7'h0, 23'h0, 23'h2);
      pc_op(5'b10000, 7'h0, 23'h1235, 23'h1234);
      pc_op(5'b00010, 7'h3, 23'h0, 23'hA);
      pc_op(5'b00011, 7'h5, 23'h0, 23'h10A);
      pc_op(5'b11010, 7'h0, 23'h4000, 23'h4);
      i_ce = 1'b0;
      pc_op(5'b01000, 7'h0, 23'h0, 23'h4);
      i_ce = 1'b1;
      $display("counter test done");
   endtask

   task automatic t_prog();
      tbl(8'h0, 16'h0, 1'b0, msd_pkg::RGN_RESET);
      tbl(8'h0, 16'h10, 1'b1, msd_pkg::RGN_PRI_IVT);
      tbl(8'h0, 16'h150, 1'b0, msd_pkg::RGN_ALT_IVT);
      tbl(8'h0, 16'h400, 1'b1, msd_pkg::RGN_USER);
      tbl(8'h7F, 16'hFFFE, 1'b0, msd_pkg::RGN_USER);
      tbl(8'h80, 16'h4, 1'b1, msd_pkg::RGN_CONFIG);
      tbl(8'hFF, 16'h0, 1'b0, msd_pkg::RGN_CONFIG);
      $display("program test done");
   endtask

   // Byte data is sent on both halves so either lane convention is fair.
   task automatic t_data();
      wr(16'h0800, 1'b0, 16'h1234);
      check(o_sfr_we, 1'b0);
      wr(16'h0801, 1'b1, 16'hABAB);
      rd(16'h0800, 1'b0, 16'hAB34);
      rd(16'h0801, 1'b1, 16'h00AB);
      rd(16'h0800, 1'b1, 16'h0034);
      wr(16'h77FE, 1'b0, 16'hBEEF);
      rd(16'h77FE, 1'b0, 16'hBEEF);
      rd(16'h7800, 1'b0, 16'h0000);
      rd(16'h8000, 1'b0, 16'h0000);
      rd(16'h0010, 1'b0, 16'hC010);
      rd(16'h0400, 1'b0, 16'h0000);
      wr(16'h0804, 1'b0, 16'h5555);
      wr(16'h0805, 1'b0, 16'hAAAA);
      check({o_addr_trap, o_sfr_we}, 2'b10);
      rd(16'h0804, 1'b0, 16'h5555);
      rd(16'h0805, 1'b0, 16'h5555);
      $display("data space test done");
   endtask

   task automatic t_write();
      wr(16'h0020, 1'b0, 16'h1357);
      check({o_sfr_we, o_sfr_lane, o_addr_trap}, 4'b1110);
      check(o_sfr_addr, 16'h0020);
      check(o_sfr_wdata, 16'h1357);
      wr(16'h0021, 1'b1, 16'hABAB);
      check({o_sfr_we, o_sfr_lane, o_sfr_addr}, 19'h60020);
      wr(16'h0020, 1'b1, 16'hCDCD);
      check({o_sfr_we, o_sfr_lane}, 3'b101);
      @(negedge i_sys_clk);
      check(o_sfr_we, 1'b0);
      $display("sfr write test done");
   endtask

   // Main sequence.
   initial begin
      {i_rst_n, i_pc_load, i_pc_step, i_pc_down, i_vector_sel, i_vector_alt} = '0;
      {i_table_req, i_table_wr, i_table_upper, i_rd_req, i_rd_byte, i_wr_req, i_wr_byte} = '0;
      {i_vector_num, i_table_page_register, i_table_offset, i_pc_load_value} = '0;
      {i_rd_ea, i_wr_ea, i_wr_data} = '0;
      i_ce = 1'b1;
      repeat (12) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      @(negedge i_sys_clk);
      t_reset();
      t_pc();
      t_prog();
      t_data();
      t_write();
      test_done();
   end
endmodule
